// ===== sahi_top.sv
// serial control and readout logic of a 10-bit converter with 4-bit channel address
// Functional notes
// RULE1: result output is undriven while chip select is high, driven while low.
// RULE2: on chip select low, the previous result's MSB appears first.
// RULE3: each later falling shift edge presents the next lower bit; LSB on ninth.
// RULE4: tenth falling edge forces the output low; extra clocks read zeros.
// RULE5: end-of-conversion drops after the tenth shift clock, stays low until ready.
// RULE6: four address bits taken on the first four rising shift edges.
// RULE7: sampling runs from the fourth to the tenth falling shift edge.
// RULE8: tenth falling edge hands the conversion to the system-clock controller.
// RULE9: shift clock and address are ignored while chip select is high.
// RULE10: chip select low enables shift clock, address and the result output.
// RULE11: host gives 10 to 16 shift clocks per transfer.
// RULE12: host sends address and reads previous result in the same transfer.
// RULE13: channel address travels most significant bit first.
// RULE14: after four address bits, the address input is ignored until next transfer.
// RULE15: chip select falling resets transfer counters and control state.
// RULE16: end-of-conversion returns high when a fresh result is available.
// RULE17: conversion lasts a fixed parameter of system cycles, then a result latches.
`timescale 1ns/1ps
`include "sahi_params.svh"
module sahi_top #(
	parameter int RES_W       = `SAHI_RES_W,
	parameter int ADDR_W      = `SAHI_ADDR_W,
	parameter int CONV_CYCLES = `SAHI_CONV_CYCLES,
	parameter int BUF_DEPTH   = `SAHI_BUF_DEPTH
) (
	input  wire logic              I_SYS_CLK,
	input  wire logic              I_RSTN,
	input  wire logic              I_CLK_EN,
	input  wire logic              I_SHIFT_CLK,
	input  wire logic              I_CS_N,
	input  wire logic              I_ADDRESS,
	input  wire logic [RES_W-1:0]  I_CONV_RESULT,
	output logic                   O_DATA_OUT,
	output logic                   O_DATA_OE,
	output logic                   O_EOC,
	output logic                   O_SAMPLE,
	output logic                   O_CONVERTING,
	output logic [ADDR_W-1:0]      O_CHANNEL
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic                     link_rst;
	logic                     hard_rst_q;
	logic                     link_clr_q;
	logic [`SAHI_RISE_W-1:0]  rise_cnt_q;
	logic [ADDR_W-1:0]        addr_q;
	logic [`SAHI_FALL_W-1:0]  fall_cnt_q;
	logic [`SAHI_FALL_W-1:0]  fall_nxt;
	logic                     bit_q;
	logic                     sample_q;
	logic                     done_tgl_q;
	logic [ADDR_W-1:0]        chan_hold_q;
	logic                     cs_s1_q;
	logic                     cs_s2_q;
	logic                     done_s1_q;
	logic                     done_s2_q;
	logic                     done_s3_q;
	logic                     start_evt;
	logic                     oe_q;
	logic                     eoc_q;
	logic                     load_ok_q;
	logic [RES_W-1:0]         shown_q;
	logic [RES_W-1:0]         result_q;
	logic [ADDR_W-1:0]        channel_q;
	logic [`SAHI_TIMER_W-1:0] timer_q;
	sahi_pkg::sahi_state_t    state_q;
	logic                     pop;

	sahi_buf_if #(.W(RES_W)) res_buf ();

	function automatic logic bit_at(input logic [RES_W-1:0] word, input logic [`SAHI_FALL_W-1:0] n);
		if (int'(n) < RES_W) begin
			return word[RES_W-1-int'(n)];
		end
		return 1'b0;
	endfunction

	// ----------------------------------------
	// link reset
	// ----------------------------------------
	// chip select high holds transfer state other than done_tgl_q and chan_hold_q cleared; a system-side pulse
	// restarts the sequence when chip select stays low between conversions.
	// both sources are glitch-free: a pin level and a flop.
	assign link_rst = I_CS_N | link_clr_q; // RULE9 RULE15

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			hard_rst_q <= 1'b1;
		end else begin
			hard_rst_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// link domain: address capture
	// ----------------------------------------
	always_ff @(posedge I_SHIFT_CLK or posedge link_rst) begin
		if (link_rst) begin
			rise_cnt_q <= '0;
			addr_q     <= '0;
		end else if (rise_cnt_q < `SAHI_RISE_W'(ADDR_W)) begin // RULE14
			addr_q     <= {addr_q[ADDR_W-2:0], I_ADDRESS}; // RULE6 RULE13
			rise_cnt_q <= rise_cnt_q + `SAHI_RISE_W'(1);
		end
	end

	// ----------------------------------------
	// link domain: result shift and sampling
	// ----------------------------------------
	assign fall_nxt = fall_cnt_q + `SAHI_FALL_W'(1);

	// shown_q is only replaced while the link sits in reset or at the
	// restart pulse, so it is stable whenever these edges read it
	always_ff @(negedge I_SHIFT_CLK or posedge link_rst) begin
		if (link_rst) begin
			fall_cnt_q <= '0;
			bit_q      <= 1'b0;
			sample_q   <= 1'b0;
		end else begin
			if (fall_cnt_q != `SAHI_FALL_MAX) begin
				fall_cnt_q <= fall_nxt;
			end
			// the count saturates at its top, where fall_nxt wraps to zero;
			// the tail must stay low there instead of replaying the msb
			if (fall_cnt_q == `SAHI_FALL_MAX) begin
				bit_q <= 1'b0; // RULE4
			end else begin
				bit_q <= bit_at(shown_q, fall_nxt); // RULE3 RULE4
			end
			if (fall_nxt == `SAHI_SAMPLE_FALL) begin
				sample_q <= 1'b1; // RULE7
			end else if (fall_nxt == `SAHI_LAST_FALL) begin
				sample_q <= 1'b0; // RULE7
			end
		end
	end

	// survives chip select so a quick release after the tenth edge still
	// reaches the system side
	always_ff @(negedge I_SHIFT_CLK or posedge hard_rst_q) begin
		if (hard_rst_q) begin
			done_tgl_q  <= 1'b0;
			chan_hold_q <= '0;
		end else if (!link_clr_q && fall_nxt == `SAHI_LAST_FALL) begin
			done_tgl_q  <= ~done_tgl_q; // RULE8
			chan_hold_q <= addr_q;
		end
	end

	// msb must appear before any shift edge exists, so the first bit is
	// taken from the held result rather than the shift flop
	assign O_DATA_OUT = (fall_cnt_q == '0) ? shown_q[RES_W-1] : bit_q; // RULE2
	assign O_SAMPLE   = sample_q;

	// ----------------------------------------
	// crossings into the system domain
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			cs_s1_q   <= 1'b1;
			cs_s2_q   <= 1'b1;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
		end else if (I_CLK_EN) begin
			cs_s1_q   <= I_CS_N;
			cs_s2_q   <= cs_s1_q;
			done_s1_q <= done_tgl_q;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
		end
	end

	assign start_evt = I_CLK_EN & (done_s2_q ^ done_s3_q);

	// ----------------------------------------
	// output enable
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			oe_q <= 1'b0;
		end else if (I_CLK_EN) begin
			oe_q <= ~cs_s2_q; // RULE1 RULE10
		end
	end

	assign O_DATA_OE = oe_q;

	// ----------------------------------------
	// conversion controller
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			state_q   <= sahi_pkg::ST_IDLE;
			timer_q   <= '0;
			result_q  <= `SAHI_RST_RESULT;
			channel_q <= '0;
		end else if (I_CLK_EN) begin
			unique case (state_q)
				sahi_pkg::ST_IDLE: begin
					if (start_evt) begin
						channel_q <= chan_hold_q; // RULE8
						timer_q   <= `SAHI_TIMER_W'(CONV_CYCLES - 1);
						state_q   <= sahi_pkg::ST_CONV;
					end
				end
				sahi_pkg::ST_CONV: begin
					if (timer_q == '0) begin
						result_q <= I_CONV_RESULT; // RULE17
						state_q  <= sahi_pkg::ST_PUSH;
					end else begin
						timer_q <= timer_q - `SAHI_TIMER_W'(1); // RULE17
					end
				end
				sahi_pkg::ST_PUSH: begin
					// waits here while the buffer is full
					if (res_buf.in_ready) begin
						state_q <= sahi_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= sahi_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign res_buf.in_valid = (state_q == sahi_pkg::ST_PUSH);
	assign res_buf.in_data  = result_q;

	sahi_fifo #(
		.W     (RES_W),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.i_clk   (I_SYS_CLK),
		.i_rst_n (I_RSTN),
		.i_en    (I_CLK_EN),
		.bus     (res_buf)
	);

	// ----------------------------------------
	// result hand-over and end of conversion
	// ----------------------------------------
	// a new result may only replace the shown one once the current
	// transfer has passed its data bits or chip select is released
	assign res_buf.out_ready = load_ok_q;
	assign pop               = I_CLK_EN & load_ok_q & res_buf.out_valid;

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			load_ok_q <= 1'b1;
		end else if (I_CLK_EN) begin
			if (start_evt || cs_s2_q) begin
				load_ok_q <= 1'b1;
			end else if (pop) begin
				load_ok_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			shown_q <= `SAHI_RST_RESULT;
		end else if (pop) begin
			shown_q <= res_buf.out_data;
		end
	end

	// start wins over completion only when both land together, which the
	// conversion time makes impossible for a single transfer
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			eoc_q <= `SAHI_RST_EOC;
		end else if (I_CLK_EN) begin
			if (start_evt) begin
				eoc_q <= 1'b0; // RULE5
			end else if (pop) begin
				eoc_q <= 1'b1; // RULE16
			end
		end
	end

	// restart pulse for continuous chip select: reopens the sequence
	// together with the rising end-of-conversion
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			link_clr_q <= 1'b0;
		end else if (I_CLK_EN) begin
			link_clr_q <= pop & ~cs_s2_q; // RULE16 RULE15
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RSTN) begin
			O_CONVERTING <= 1'b0;
		end else if (I_CLK_EN) begin
			O_CONVERTING <= (state_q == sahi_pkg::ST_CONV);
		end
	end

	assign O_EOC     = eoc_q;
	assign O_CHANNEL = channel_q;
endmodule

// ===== sahi_params.svh
// constants of the serial converter host interface
`ifndef SAHI_PARAMS_SVH
`define SAHI_PARAMS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define SAHI_RES_W        10
`define SAHI_ADDR_W       4
`define SAHI_FALL_W       4
`define SAHI_RISE_W       3
`define SAHI_TIMER_W      16

// ----------------------------------------
// shift-clock edge numbers
// ----------------------------------------
`define SAHI_SAMPLE_FALL  4'h4
`define SAHI_LAST_FALL    4'hA
`define SAHI_FALL_MAX     4'hF

// ----------------------------------------
// timing
// ----------------------------------------
`define SAHI_CONV_TIME_NS 2000
`define SAHI_SYS_CLK_MHZ  10
`define SAHI_CONV_CYCLES  ((`SAHI_CONV_TIME_NS * `SAHI_SYS_CLK_MHZ) / 1000)
`define SAHI_BUF_DEPTH    2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SAHI_RST_RESULT   10'h000
`define SAHI_RST_EOC      1'b1

`endif

// ===== sahi_pkg.sv
// types of the serial converter host interface
package sahi_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONV,
		ST_PUSH
	} sahi_state_t;

endpackage

// ===== sahi_buf_if.sv
// valid/ready carrier between the converter control and its result buffer
`timescale 1ns/1ps
interface sahi_buf_if #(
	parameter int W = 10
);
	logic         in_valid;
	logic         in_ready;
	logic [W-1:0] in_data;
	logic         out_valid;
	logic         out_ready;
	logic [W-1:0] out_data;

	modport buffer (
		input  in_valid,
		input  in_data,
		input  out_ready,
		output in_ready,
		output out_valid,
		output out_data
	);

	modport user (
		output in_valid,
		output in_data,
		output out_ready,
		input  in_ready,
		input  out_valid,
		input  out_data
	);
endinterface

// ===== sahi_fifo.sv
// small result buffer, flip-flop storage, valid/ready on both sides
`timescale 1ns/1ps
module sahi_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 2
) (
	input  wire logic   i_clk,
	input  wire logic   i_rst_n,
	input  wire logic   i_en,
	sahi_buf_if.buffer  bus
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic          push;
	logic          pop;

	function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1)) begin
			return '0;
		end
		return p + PW'(1);
	endfunction

	// ----------------------------------------
	// handshake
	// ----------------------------------------
	assign bus.in_ready  = (count_q != CW'(DEPTH));
	assign bus.out_valid = (count_q != '0);
	assign bus.out_data  = mem_q[rd_ptr_q];
	assign push          = i_en & bus.in_valid & bus.in_ready;
	assign pop           = i_en & bus.out_valid & bus.out_ready;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= bus.in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= ptr_next(wr_ptr_q);
			end
			if (pop) begin
				rd_ptr_q <= ptr_next(rd_ptr_q);
			end
			if (push && !pop) begin
				count_q <= count_q + CW'(1);
			end else if (pop && !push) begin
				count_q <= count_q - CW'(1);
			end
		end
	end
endmodule

// ===== sahi_top_chk.sv
// port-level assertions of the serial converter host interface
`timescale 1ns/1ps
module sahi_top_chk #(
	parameter int RES_W       = 10,
	parameter int ADDR_W      = 4,
	parameter int CONV_CYCLES = 20
) (
	input logic              I_SYS_CLK,
	input logic              I_RSTN,
	input logic              I_CLK_EN,
	input logic              I_SHIFT_CLK,
	input logic              I_CS_N,
	input logic              I_ADDRESS,
	input logic [RES_W-1:0]  I_CONV_RESULT,
	input logic              O_DATA_OUT,
	input logic              O_DATA_OE,
	input logic              O_EOC,
	input logic              O_SAMPLE,
	input logic              O_CONVERTING,
	input logic [ADDR_W-1:0] O_CHANNEL
);
	localparam int EOC_MIN = CONV_CYCLES;
	localparam int EOC_MAX = CONV_CYCLES + 8;
	logic [3:0] fall_q;
	logic       ten_seen;
	logic       eoc_d;
	logic       restart;

	// in the system cycle in which eoc rises the frame restarts under a held chip select
	always_ff @(posedge I_SYS_CLK) begin
		eoc_d <= O_EOC;
	end
	assign restart = O_EOC & ~eoc_d;

	// falling shift edges of this frame, saturating at 15 inside the longest frame
	always_ff @(negedge I_SHIFT_CLK or posedge I_CS_N or posedge restart) begin
		if (I_CS_N || restart)
			fall_q <= 4'h0;
		else if (fall_q != 4'hF)
			fall_q <= fall_q + 4'h1;
	end
	assign ten_seen = (fall_q >= 4'hA);

	a_oe_released: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		I_CS_N [*5] |-> !O_DATA_OE) else $error("data pin driven while deselected");
	a_oe_driven: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		!I_CS_N [*5] |-> O_DATA_OE) else $error("data pin not driven while selected");
	a_cs_ignores: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		I_CS_N [*2] |-> !O_SAMPLE) else $error("sampling while deselected");
	a_eoc_drop: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		$rose(ten_seen) |-> ##[2:6] !O_EOC) else $error("eoc did not fall after tenth edge");
	a_eoc_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		$fell(O_EOC) |-> ##EOC_MIN !O_EOC) else $error("eoc rose before conversion time");
	a_eoc_return: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		$fell(O_EOC) |-> ##[1:EOC_MAX] O_EOC) else $error("eoc did not return high");
	a_conv_busy: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		O_CONVERTING |-> !O_EOC) else $error("eoc high while converting");
	a_sample_window: assert property (@(posedge I_SHIFT_CLK) disable iff (I_CS_N || !I_RSTN)
		O_SAMPLE == (fall_q >= 4'h4 && fall_q <= 4'h9)) else $error("sample window misplaced");
	a_zero_tail: assert property (@(posedge I_SHIFT_CLK) disable iff (I_CS_N || !I_RSTN)
		ten_seen |-> !O_DATA_OUT) else $error("tail bit not zero");
	a_tail_held: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
		(!I_CS_N && ten_seen) |-> !O_DATA_OUT) else $error("tail bit not held low");

	c_eoc_rise: cover property (@(posedge I_SYS_CLK) $rose(O_EOC));
	c_long_frame: cover property (@(posedge I_SHIFT_CLK) fall_q == 4'hF);
	c_oe_release: cover property (@(posedge I_SYS_CLK) $fell(O_DATA_OE));
	c_held_restart: cover property (@(posedge I_SYS_CLK) restart && !I_CS_N);
endmodule

bind sahi_top sahi_top_chk #(.RES_W(RES_W), .ADDR_W(ADDR_W), .CONV_CYCLES(CONV_CYCLES)) u_chk (
	.I_SYS_CLK, .I_RSTN, .I_CLK_EN, .I_SHIFT_CLK, .I_CS_N, .I_ADDRESS, .I_CONV_RESULT,
	.O_DATA_OUT, .O_DATA_OE, .O_EOC, .O_SAMPLE, .O_CONVERTING, .O_CHANNEL
);

// ===== sahi_host.sv
// host serial port model: chip select, shift clock, address out, result in
`timescale 1ns/1ps
module sahi_host (
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_addr,
	input  logic i_data
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_addr = 1'b0;
	end

	// one frame of 80 ns shift clocks; clock idles low outside frames
	// hold keeps chip select low after the frame, so the next one restarts on eoc
	task automatic xfer(input logic [3:0] addr, input int nclk, input bit hold, output logic [15:0] rd);
		rd = 16'h0000;
		#($urandom_range(1, 79));
		o_cs_n = 1'b0;
		#500;
		for (int n = 0; n < nclk; n++) begin
			o_addr = (n < 4) ? addr[3-n] : 1'($urandom);
			#20;
			rd = {rd[14:0], i_data};
			o_sclk = 1'b1;
			#40;
			o_sclk = 1'b0;
			#20;
		end
		#140;
		if (!hold)
			o_cs_n = 1'b1;
	endtask

	// deliberate clocking while deselected
	task automatic noise();
		repeat (6) begin
			o_addr = ~o_addr;
			#40 o_sclk = 1'b1;
			#40 o_sclk = 1'b0;
		end
	endtask
endmodule

// ===== tb_sahi_top.sv
// self-checking bench of the serial converter host interface
`timescale 1ns/1ps
module tb_sahi_top;
	localparam int CONV = 8;
	logic        I_SYS_CLK;
	logic        I_RSTN;
	logic        I_CLK_EN;
	logic        cs_n;
	logic        sclk;
	logic        addr;
	logic        data_w;
	logic [9:0]  conv_val;
	logic        o_data;
	logic        oe;
	logic        eoc;
	logic        o_sample;
	logic        o_conv;
	logic [3:0]  o_chan;
	logic [15:0] rd;
	logic [3:0]  a;
	int          n;
	int          exp_v;
	int          hist[$];
	int          failures;
	int          check_count;
	int          cyc;

	// undriven pin shows the inverse, never a lucky match
	assign data_w = oe ? o_data : ~o_data;

	sahi_top #(.CONV_CYCLES(CONV)) dut (
		.I_SYS_CLK    (I_SYS_CLK),
		.I_RSTN       (I_RSTN),
		.I_CLK_EN     (I_CLK_EN),
		.I_SHIFT_CLK  (sclk),
		.I_CS_N       (cs_n),
		.I_ADDRESS    (addr),
		.I_CONV_RESULT(conv_val),
		.O_DATA_OUT   (o_data),
		.O_DATA_OE    (oe),
		.O_EOC        (eoc),
		.O_SAMPLE     (o_sample),
		.O_CONVERTING (o_conv),
		.O_CHANNEL    (o_chan)
	);
	sahi_host host (.o_cs_n(cs_n), .o_sclk(sclk), .o_addr(addr), .i_data(data_w));

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_eoc(input logic lvl);
		int k;
		k = 0;
		while (eoc !== lvl && k < 200) begin
			@(posedge I_SYS_CLK);
			k++;
		end
		check("eoc", 16'(lvl), 16'(eoc));
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		I_SYS_CLK = 1'b0;
		forever #50 I_SYS_CLK = ~I_SYS_CLK;
	end

	// whole run needs well under a thousand cycles
	always @(posedge I_SYS_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			complete_run();
		end
	end

	initial begin
		I_RSTN = 1'b0;
		I_CLK_EN = 1'b1;
		conv_val = 10'h000;
		void'($urandom(32'hA175));
		repeat (16) @(posedge I_SYS_CLK);
		I_RSTN <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			repeat (3) @(posedge I_SYS_CLK);
			check("oe idle", cs_n ? 16'h0000 : 16'h0001, 16'(oe));
			a = 4'($urandom);
			n = 10 + (i % 7);
			conv_val <= 10'($urandom);
			if (i == 2)
				host.noise();
			host.xfer(a, n, i == 3, rd);
			exp_v = ((hist.size() > 0 ? hist[$] : 0) << 6) >> (16 - n);
			check("serial result", 16'(exp_v), rd);
			wait_eoc(1'b0);
			wait_eoc(1'b1);
			check("channel", 16'(a), 16'(o_chan));
			hist.push_back(int'(conv_val));
			if (i == 5) begin
				I_CLK_EN <= 1'b0;
				repeat (8) @(posedge I_SYS_CLK);
				I_CLK_EN <= 1'b1;
			end
			if (i == 7) begin
				I_RSTN <= 1'b0;
				repeat (4) @(posedge I_SYS_CLK);
				I_RSTN <= 1'b1;
				hist.delete();
			end
			$display("test %0d done", i);
		end
		complete_run();
	end
endmodule
